// >>> rtl/blm_device.sv
// Purpose: device end: identity, force, temperature, shadow and memory control
// Assumes: bus requests spaced by their ack; dieTemp synchronous
// Notes: memory image survives arst_n, it only loses data at power-off
`timescale 1ns/1ns
`include "blm_regs.svh"
module blm_device
  import blm_pkg::*;
#(
  parameter logic PANEL_CODE = 1'h0,        // arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h5,  // arbitrary value
  parameter logic [2:0] VERSION_CODE = 3'h1, // arbitrary value
  parameter int OP_CYCLES = `BLM_NVM_OP_CYC,
  parameter logic [63:0] NVM_INIT = 64'h0
)
(
  input wire logic core_clk, // device clock
  input wire logic arst_n, // power-on reset
  blm_if.dev bus, // register port
  input wire logic [10:0] dieTemp, // live temperature reading
  output logic [3:0] forceFull, // per output full duty
  output logic [63:0] shadowCfg, // live configuration bytes
  output logic nvmBusy // store or load in progress
);

  typedef enum {S_IDLE, S_STORE, S_LOAD} blm_dev_state_e;

  blm_dev_state_e state_r;
  logic [31:0] opCnt_r;
  logic ack_r;
  logic [7:0] rdata_r;
  logic [3:0] force_r;
  logic [2:0] heatLow_r;
  logic arm_r;
  logic store_r;
  logic load_r;
  logic [7:0] shadow_r [8];
  logic [63:0] nvmMem_r = NVM_INIT;
  logic wrStb;
  logic rdStb;
  logic ctlWr;
  logic startStore;
  logic startLoad;
  logic opDone;
  logic loadDone;
  logic storeDone;
  logic [63:0] shadowFlat;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // shadow window test used by both read and write paths
  function automatic logic inShadow(input logic [7:0] a);
    inShadow = (a >= `BLM_ADDR_SHADOW0) && (a <= `BLM_ADDR_SHADOW7);
  endfunction

  assign wrStb = bus.req && bus.we;
  assign rdStb = bus.req && !bus.we;
  assign ctlWr = wrStb && (bus.addr == `BLM_ADDR_NVM_CTL);
  // arm must already stand before the store or load bit is written
  assign startStore = ctlWr && bus.wdata[`BLM_CTL_STORE_BIT] && arm_r
    && (state_r == S_IDLE);
  assign startLoad = ctlWr && bus.wdata[`BLM_CTL_LOAD_BIT] && arm_r
    && (state_r == S_IDLE) && !startStore;
  assign opDone = (state_r != S_IDLE) && (opCnt_r == 32'(OP_CYCLES - 1));
  assign loadDone = opDone && (state_r == S_LOAD);
  assign storeDone = opDone && (state_r == S_STORE);

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // unmapped offsets, including the power register, read as zero
  function automatic logic [7:0] readMux(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (inShadow(a))
    begin
      v = shadow_r[a[2:0]];
    end
    else
    begin
      case (a)
        `BLM_ADDR_IDENT: v = {PANEL_CODE, MAKER_CODE, VERSION_CODE};
        `BLM_ADDR_FORCE: v = {4'h0, force_r};
        `BLM_ADDR_HEAT_UP: v = dieTemp[10:3];
        `BLM_ADDR_HEAT_LO: v = {heatLow_r, 5'h00};
        `BLM_ADDR_NVM_CTL: v = {(state_r == S_IDLE), 4'h0, arm_r, store_r, load_r};
        default: v = 8'h00;
      endcase
    end
    readMux = v;
  endfunction

  // ----------------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------------
  // answer registered one cycle after every request, writes read back zero
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      ack_r <= bus.req;
      if (rdStb)
      begin
        rdata_r <= readMux(bus.addr);
      end
      else if (bus.req)
      begin
        rdata_r <= 8'h00;
      end
    end
  end

  assign bus.ack = ack_r;
  assign bus.rdata = rdata_r;

  // ----------------------------------------------------------------------
  // force register
  // ----------------------------------------------------------------------
  // upper nibble is not stored and reads zero
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      force_r <= `BLM_RST_FORCE;
    end
    else if (wrStb && (bus.addr == `BLM_ADDR_FORCE))
    begin
      force_r <= bus.wdata[3:0];
    end
  end

  assign forceFull = force_r;

  // ----------------------------------------------------------------------
  // temperature latch
  // ----------------------------------------------------------------------
  // low bits frozen at the upper read so the pair matches
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      heatLow_r <= `BLM_RST_HEAT_LO;
    end
    else if (rdStb && (bus.addr == `BLM_ADDR_HEAT_UP))
    begin
      heatLow_r <= dieTemp[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // memory control bits
  // ----------------------------------------------------------------------
  // plain storage; the sequencer only looks at them on a write
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arm_r <= 1'b0;
      store_r <= 1'b0;
      load_r <= 1'b0;
    end
    else if (ctlWr)
    begin
      arm_r <= bus.wdata[`BLM_CTL_ARM_BIT];
      store_r <= bus.wdata[`BLM_CTL_STORE_BIT];
      load_r <= bus.wdata[`BLM_CTL_LOAD_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // leaves reset in a load so the stored image comes back unasked
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= S_LOAD;
      opCnt_r <= 32'h0;
    end
    else
    begin
      case (state_r)
        S_IDLE:
        begin
          opCnt_r <= 32'h0;
          if (startStore)
          begin
            state_r <= S_STORE;
          end
          else if (startLoad)
          begin
            state_r <= S_LOAD;
          end
        end
        S_STORE, S_LOAD:
        begin
          if (opDone)
          begin
            state_r <= S_IDLE;
            opCnt_r <= 32'h0;
          end
          else
          begin
            opCnt_r <= opCnt_r + 32'h1;
          end
        end
        default:
        begin
          state_r <= S_IDLE;
          opCnt_r <= 32'h0;
        end
      endcase
    end
  end

  assign nvmBusy = (state_r != S_IDLE);

  // ----------------------------------------------------------------------
  // shadow bytes
  // ----------------------------------------------------------------------
  // a finishing load wins over a host write landing in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_shadow
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          shadow_r[gi] <= 8'h00;
        end
        else if (loadDone)
        begin
          shadow_r[gi] <= nvmMem_r[gi*8 +: 8];
        end
        else if (wrStb && inShadow(bus.addr) && (bus.addr[2:0] == 3'(gi)))
        begin
          shadow_r[gi] <= bus.wdata;
        end
      end
      assign shadowFlat[gi*8 +: 8] = shadow_r[gi];
    end
  endgenerate

  // effective at once, no store step in the path
  assign shadowCfg = shadowFlat;

  // ----------------------------------------------------------------------
  // non-volatile image
  // ----------------------------------------------------------------------
  // not on arst_n: a power-on reset must not wipe stored data
  always_ff @(posedge core_clk)
  begin
    if (storeDone)
    begin
      nvmMem_r <= shadowFlat;
    end
  end

endmodule // blm_device

// >>> rtl/blm_host.sv
// Purpose: host end: single accesses and the documented register sequences
// Assumes: device answers each request with ack
// Notes: memory sequences refused unless ALLOW_NVM is set
`timescale 1ns/1ns
`include "blm_regs.svh"
module blm_host
  import blm_pkg::*;
#(
  parameter int WAIT_CYCLES = `BLM_NVM_WAIT_CYC,
  parameter logic ALLOW_NVM = 1'b0
)
(
  input wire logic core_clk, // host clock
  input wire logic arst_n, // reset
  blm_if.host bus, // register port
  input wire logic cmdValid, // command offered
  input wire blm_op_e cmdOp, // command kind
  input wire logic [7:0] cmdAddr, // address for single access
  input wire logic [7:0] cmdData, // data for single write
  input wire logic [63:0] storeImage, // shadow bytes for a store
  output logic cmdReady, // idle, command accepted
  output logic donePulse, // command finished
  output logic refused, // last command refused
  output logic [7:0] readResult, // last single read
  output logic [10:0] tempResult // last temperature pair
);

  typedef enum {H_IDLE, H_ISSUE, H_WAIT, H_DELAY} blm_host_state_e;

  blm_host_state_e state_r;
  blm_op_e op_r;
  logic [3:0] idx_r;
  logic [7:0] cAddr_r;
  logic [7:0] cData_r;
  logic [63:0] img_r;
  logic [31:0] waitCnt_r;
  logic req_r;
  logic we_r;
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic done_r;
  logic refused_r;
  logic [7:0] rd_r;
  logic [10:0] temp_r;
  blm_step_s step;

  // ----------------------------------------------------------------------
  // sequence table
  // ----------------------------------------------------------------------
  function automatic blm_step_s stepOf(input blm_op_e op, input logic [3:0] i,
    input logic [7:0] a, input logic [7:0] d, input logic [63:0] img);
    blm_step_s s;
    s = '{last: 1'b0, delay: 1'b0, we: 1'b1, addr: `BLM_ADDR_NVM_CTL, data: 8'h00};
    case (op)
      OP_WRITE: s = '{last: 1'b1, delay: 1'b0, we: 1'b1, addr: a, data: d};
      OP_READ: s = '{last: 1'b1, delay: 1'b0, we: 1'b0, addr: a, data: 8'h00};
      // upper first so the lower byte matches it
      OP_TEMP: s = '{last: (i == 4'h1), delay: 1'b0, we: 1'b0,
        addr: (i == 4'h0) ? `BLM_ADDR_HEAT_UP : `BLM_ADDR_HEAT_LO, data: 8'h00};
      OP_STORE:
      begin
        if (i == 4'h0)
        begin
          s.addr = `BLM_ADDR_POWER;
          s.data = `BLM_POWER_ON_VAL;
        end
        else if (i <= 4'h8)
        begin
          s.addr = `BLM_ADDR_SHADOW0 + 8'(i - 4'h1);
          s.data = img[(i - 4'h1)*8 +: 8];
        end
        else if (i == 4'h9)
        begin
          s.data = `BLM_CTL_ARM_VAL;
        end
        else if (i == 4'hA)
        begin
          s.data = `BLM_CTL_STORE_VAL;
        end
        else if (i == 4'hB)
        begin
          s.delay = 1'b1;
        end
        else
        begin
          s.last = 1'b1;
        end
      end
      OP_LOAD:
      begin
        case (i)
          4'h0:
          begin
            s.addr = `BLM_ADDR_POWER;
            s.data = `BLM_POWER_ON_VAL;
          end
          4'h1: s.data = `BLM_CTL_ARM_VAL;
          4'h2: s.data = `BLM_CTL_LOAD_VAL;
          4'h3: s.delay = 1'b1;
          default: s.last = 1'b1;
        endcase
      end
      default: s.last = 1'b1;
    endcase
    stepOf = s;
  endfunction

  assign step = stepOf(op_r, idx_r, cAddr_r, cData_r, img_r);

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // memory control is kept off production parts unless enabled
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= H_IDLE;
      op_r <= OP_WRITE;
      idx_r <= 4'h0;
      cAddr_r <= 8'h00;
      cData_r <= 8'h00;
      img_r <= 64'h0;
      waitCnt_r <= 32'h0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      rd_r <= 8'h00;
      temp_r <= 11'h000;
    end
    else
    begin
      done_r <= 1'b0;
      req_r <= 1'b0;
      case (state_r)
        H_IDLE:
        begin
          if (cmdValid)
          begin
            if (((cmdOp == OP_STORE) || (cmdOp == OP_LOAD)) && !ALLOW_NVM)
            begin
              refused_r <= 1'b1;
              done_r <= 1'b1;
            end
            else
            begin
              refused_r <= 1'b0;
              op_r <= cmdOp;
              cAddr_r <= cmdAddr;
              cData_r <= cmdData;
              img_r <= storeImage;
              idx_r <= 4'h0;
              state_r <= H_ISSUE;
            end
          end
        end
        H_ISSUE:
        begin
          if (step.delay)
          begin
            waitCnt_r <= 32'h0;
            state_r <= H_DELAY;
          end
          else
          begin
            req_r <= 1'b1;
            we_r <= step.we;
            addr_r <= step.addr;
            wdata_r <= step.data;
            state_r <= H_WAIT;
          end
        end
        H_WAIT:
        begin
          if (bus.ack)
          begin
            if (op_r == OP_READ)
            begin
              rd_r <= bus.rdata;
            end
            if (op_r == OP_TEMP && idx_r == 4'h0)
            begin
              temp_r[10:3] <= bus.rdata;
            end
            if (op_r == OP_TEMP && idx_r == 4'h1)
            begin
              temp_r[2:0] <= bus.rdata[7:5];
            end
            if (step.last)
            begin
              done_r <= 1'b1;
              state_r <= H_IDLE;
            end
            else
            begin
              idx_r <= idx_r + 4'h1;
              state_r <= H_ISSUE;
            end
          end
        end
        H_DELAY:
        begin
          if (waitCnt_r == 32'(WAIT_CYCLES - 1))
          begin
            idx_r <= idx_r + 4'h1;
            state_r <= H_ISSUE;
          end
          else
          begin
            waitCnt_r <= waitCnt_r + 32'h1;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign cmdReady = (state_r == H_IDLE);
  assign donePulse = done_r;
  assign refused = refused_r;
  assign readResult = rd_r;
  assign tempResult = temp_r;
  assign bus.req = req_r;
  assign bus.we = we_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;

endmodule // blm_host

// >>> rtl/blm_if.sv
// Purpose: register port between host and device
// Assumes: one clock, request is a one-cycle pulse
// Notes: ack comes one cycle after req
`timescale 1ns/1ns
interface blm_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// >>> rtl/blm_pkg.sv
// Purpose: shared types of the backlight register block
// Assumes: constants come from blm_regs.svh
// Notes: types only
package blm_pkg;
  // host command set
  typedef enum logic [2:0] {OP_WRITE, OP_READ, OP_STORE, OP_LOAD, OP_TEMP} blm_op_e;
  // one step of a host sequence
  typedef struct packed {
    logic last;
    logic delay;
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } blm_step_s;
endpackage

// >>> rtl/blm_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 100 MHz core clock, 8-bit register port
// Notes: included by both ends; the package does not include it
//
// Summary of operation
// - low nibble forces each output full duty
// - 11-bit temperature split upper/lower registers
// - upper read latches low bits; read upper first
// - host store sequence: power, shadow, arm, store
// - store after arm copies shadow to memory
// - host load sequence; device restores shadow
// - shadow writes act at once, volatile
// - start-up auto-loads memory into shadow
// - host avoids memory control unless bench
`ifndef BLM_REGS_SVH
`define BLM_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define BLM_ADDR_POWER 8'h01
`define BLM_ADDR_IDENT 8'h03
`define BLM_ADDR_FORCE 8'h04
`define BLM_ADDR_HEAT_UP 8'h05
`define BLM_ADDR_HEAT_LO 8'h06
`define BLM_ADDR_NVM_CTL 8'h72
`define BLM_ADDR_SHADOW0 8'hA0
`define BLM_ADDR_SHADOW7 8'hA7

// ----------------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------------
`define BLM_CTL_IDLE_BIT 7
`define BLM_CTL_ARM_BIT 2
`define BLM_CTL_STORE_BIT 1
`define BLM_CTL_LOAD_BIT 0
`define BLM_RST_FORCE 4'h0
`define BLM_RST_HEAT_LO 3'h0
`define BLM_POWER_ON_VAL 8'h05
`define BLM_CTL_ARM_VAL 8'h04
`define BLM_CTL_STORE_VAL 8'h02
`define BLM_CTL_LOAD_VAL 8'h01
`define BLM_CTL_CLEAR_VAL 8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define BLM_CLK_NS 10
`define BLM_NVM_WAIT_MS 200
`define BLM_NVM_WAIT_CYC ((`BLM_NVM_WAIT_MS * 1000000) / `BLM_CLK_NS)
`define BLM_NVM_OP_CYC 1000

`endif

// >>> test/blm_port_sva.sv
// Purpose: protocol and register checks on the host to device port
// Assumes: sees the interface signals only; ack one cycle after req
// Notes: busy check stops two cycles before the count ends; idle is demanded three cycles after it ends
`timescale 1ns/1ns
module blm_port_sva #(
  parameter logic [7:0] IDENT = 8'h29,
  parameter int OP_CYCLES = 50
)
(
  input wire logic core_clk, // clock
  input wire logic arst_n, // async reset
  input wire logic req, // request pulse
  input wire logic we, // write select
  input wire logic [7:0] addr, // address
  input wire logic [7:0] wdata, // write data
  input wire logic ack, // answer pulse
  input wire logic [7:0] rdata // read data
);
  // ----------------------------------------------------------------
  // mirrors of what the device should hold
  // ----------------------------------------------------------------
  logic armed_r;
  logic [3:0] force_r;
  int opCnt_r;
  int quiet_r;
  logic rdAck;
  logic ctlWr;
  assign rdAck = ack && !we;
  assign ctlWr = req && we && addr == 8'h72;
  // arm and force bits are plain storage
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      armed_r <= 1'b0;
    else if (ctlWr)
      armed_r <= wdata[2];
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      force_r <= 4'h0;
    else if (req && we && addr == 8'h04)
      force_r <= wdata[3:0];
  // reset starts the boot load, so the count starts full
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      opCnt_r <= OP_CYCLES;
    else if (ctlWr && (wdata[1] | wdata[0]) && armed_r && opCnt_r == 0)
      opCnt_r <= OP_CYCLES;
    else if (opCnt_r != 0)
      opCnt_r <= opCnt_r - 1;
  // settle margin before idle is demanded
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      quiet_r <= 0;
    else if (opCnt_r != 0)
      quiet_r <= 0;
    else if (quiet_r < 3)
      quiet_r <= quiet_r + 1;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_ack_next; req |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_lone; !req |=> !ack; endproperty
  a_ack_lone: assert property (p_ack_lone) else $error("ack without request");
  property p_wr_zero; ack && we |-> rdata == 8'h00; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("rdata not zero after write");
  property p_ident; rdAck && addr == 8'h03 |-> rdata == IDENT; endproperty
  a_ident: assert property (p_ident) else $error("identity value wrong");
  property p_force; rdAck && addr == 8'h04 |-> rdata == {4'h0, force_r}; endproperty
  a_force: assert property (p_force) else $error("force register readback wrong");
  property p_heat_lo; rdAck && addr == 8'h06 |-> rdata[4:0] == 5'h00; endproperty
  a_heat_lo: assert property (p_heat_lo) else $error("lower heat spare bits set");
  property p_unmapped; rdAck && addr == 8'h01 |-> rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_busy; rdAck && addr == 8'h72 && opCnt_r > 2 |-> !rdata[7]; endproperty
  a_busy: assert property (p_busy) else $error("idle flag set while busy");
  property p_idle; rdAck && addr == 8'h72 && quiet_r == 3 |-> rdata[7]; endproperty
  a_idle: assert property (p_idle) else $error("idle flag clear while idle");
endmodule // blm_port_sva

// >>> test/testbench.sv
// Purpose: end to end test of host and device ends of the register port
// Assumes: short counts: device op 50 cycles, host wait 2000 cycles
// Notes: a second device is driven directly to break the host's rules
`timescale 1ns/1ns
module testbench;
  import blm_pkg::*;
  localparam logic [63:0] IMG0 = 64'h0123456789ABCDEF;
  localparam logic [63:0] IMG1 = 64'hF0E1D2C3B4A59687;
  localparam logic [7:0] IDENT = {1'h1, 4'hA, 3'h3}; // arbitrary codes
  localparam int OP_CYC = 50;
  localparam int WAIT_CYC = 2000;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmdValid = 1'b0;
  blm_op_e cmdOp = OP_READ;
  logic [7:0] cmdAddr = 8'h00;
  logic [7:0] cmdData = 8'h00;
  logic [63:0] storeImage = IMG1;
  logic [10:0] dieTemp = 11'h000;
  logic cmdReady, donePulse, refused, nvmBusy;
  logic cmdValid2 = 1'b0;
  logic cmdReady2, donePulse2, refused2;
  logic [7:0] readResult;
  logic [10:0] tempResult;
  logic [3:0] forceFull;
  logic [63:0] shadowCfg;
  int miscompares = 0;
  int n_checks = 0;
  blm_if bus1 ();
  blm_if bus2 ();
  blm_if bus3 ();
  // nothing answers on the third port; a refused command never asks
  assign bus3.ack = 1'b0;
  assign bus3.rdata = 8'h00;

  // ----------------------------------------------------------------
  // ends under test
  // ----------------------------------------------------------------
  // memory sequences enabled: this bench is a validation setup
  blm_host #(.WAIT_CYCLES(WAIT_CYC), .ALLOW_NVM(1'b1)) u_blm_host (
    .core_clk(core_clk), .arst_n(arst_n), .bus(bus1.host), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .storeImage(storeImage), .cmdReady(cmdReady),
    .donePulse(donePulse), .refused(refused), .readResult(readResult), .tempResult(tempResult));
  blm_device #(.PANEL_CODE(IDENT[7]), .MAKER_CODE(IDENT[6:3]), .VERSION_CODE(IDENT[2:0]),
    .OP_CYCLES(OP_CYC), .NVM_INIT(IMG0)) u_blm_device (.core_clk(core_clk), .arst_n(arst_n),
    .bus(bus1.dev), .dieTemp(dieTemp), .forceFull(forceFull), .shadowCfg(shadowCfg),
    .nvmBusy(nvmBusy));
  // second device faces the bench directly
  blm_device #(.OP_CYCLES(OP_CYC)) u_blm_device_2 (.core_clk(core_clk), .arst_n(arst_n),
    .bus(bus2.dev), .dieTemp(dieTemp), .forceFull(), .shadowCfg(), .nvmBusy());
  // production host with default settings; it must never reach its bus
  blm_host u_blm_host_2 (.core_clk(core_clk), .arst_n(arst_n), .bus(bus3.host),
    .cmdValid(cmdValid2), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .storeImage(storeImage), .cmdReady(cmdReady2), .donePulse(donePulse2),
    .refused(refused2), .readResult(), .tempResult());
  blm_port_sva #(.IDENT(IDENT), .OP_CYCLES(OP_CYC)) u_blm_port_sva (.core_clk(core_clk),
    .arst_n(arst_n), .req(bus1.req), .we(bus1.we), .addr(bus1.addr), .wdata(bus1.wdata),
    .ack(bus1.ack), .rdata(bus1.rdata));

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one host command, bounded wait for its done pulse
  task automatic cmd(input blm_op_e op, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    cmdValid = 1'b1;
    cmdOp = op;
    cmdAddr = a;
    cmdData = d;
    @(negedge core_clk);
    cmdValid = 1'b0;
    while (donePulse !== 1'b1 && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("done", 1'b1, donePulse);
    chk("ready", 1'b1, cmdReady);
  endtask
  // direct access on the second port; one idle cycle keeps the spacing
  task automatic acc2(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge core_clk);
    bus2.req = 1'b1;
    bus2.we = w;
    bus2.addr = a;
    bus2.wdata = d;
    @(negedge core_clk);
    bus2.req = 1'b0;
    chk("ack", 1'b1, bus2.ack);
    q = bus2.rdata;
    @(negedge core_clk);
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] q;
    logic [7:0] pat [2];
    pat = '{8'hFF, 8'h05};
    bus2.req = 1'b0;
    bus2.we = 1'b0;
    bus2.addr = 8'h00;
    bus2.wdata = 8'h00;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    cmd(OP_READ, 8'h72, 8'h00);
    chk("ctl in boot", 8'h00, readResult);
    repeat (60) @(negedge core_clk);
    chk("boot image", IMG0, shadowCfg);
    chk("busy", 1'b0, nvmBusy);
    $display("test boot done");
    // writing a read-only place must not disturb it
    cmd(OP_WRITE, 8'h03, 8'h00);
    cmd(OP_READ, 8'h03, 8'h00);
    chk("ident", IDENT, readResult);
    cmd(OP_READ, 8'h01, 8'h00);
    chk("unmapped", 8'h00, readResult);
    foreach (pat[i])
    begin
      cmd(OP_WRITE, 8'h04, pat[i]);
      chk("force pins", pat[i][3:0], forceFull);
      cmd(OP_READ, 8'h04, 8'h00);
      chk("force reg", {4'h0, pat[i][3:0]}, readResult);
    end
    $display("test ident force done");
    dieTemp = 11'h5A3;
    cmd(OP_TEMP, 8'h00, 8'h00);
    chk("temp pair", 11'h5A3, tempResult);
    // live value moves between the two reads; lower part must stay frozen
    dieTemp = 11'h2C6;
    acc2(1'b0, 8'h05, 8'h00, q);
    chk("heat upper", 8'h58, q);
    dieTemp = 11'h139;
    acc2(1'b0, 8'h06, 8'h00, q);
    chk("heat lower", 8'hC0, q);
    $display("test temperature done");
    cmd(OP_WRITE, 8'hA3, 8'h5C);
    chk("shadow now", 8'h5C, shadowCfg[31:24]);
    cmd(OP_STORE, 8'h00, 8'h00);
    chk("shadow stored", IMG1, shadowCfg);
    cmd(OP_READ, 8'h72, 8'h00);
    chk("ctl idle", 8'h80, readResult);
    cmd(OP_WRITE, 8'hA0, 8'h11);
    chk("shadow volatile", {IMG1[63:8], 8'h11}, shadowCfg);
    cmd(OP_LOAD, 8'h00, 8'h00);
    chk("loaded", IMG1, shadowCfg);
    // reset in mid-run: stored image must come back by itself
    arst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (60) @(negedge core_clk);
    chk("reboot image", IMG1, shadowCfg);
    $display("test store load done");
    // production host turns memory commands away without bus traffic
    @(negedge core_clk);
    cmdValid2 = 1'b1;
    cmdOp = OP_LOAD;
    @(negedge core_clk);
    cmdValid2 = 1'b0;
    chk("refused", 1'b1, refused2);
    chk("refusal done", 1'b1, donePulse2);
    chk("refusal no req", 1'b0, bus3.req);
    chk("ready after refusal", 1'b1, cmdReady2);
    chk("main not refused", 1'b0, refused);
    $display("test refusal done");
    // store request without arming: bits kept, no operation
    acc2(1'b1, 8'h72, 8'h02, q);
    acc2(1'b0, 8'h72, 8'h00, q);
    chk("no store unarmed", 8'h82, q);
    $display("test misuse done");
    test_done;
  end

  // hang guard, well beyond the expected run
  initial
  begin
    #200000;
    miscompares++;
    test_done;
  end
endmodule // testbench
